// ==== hdl/eq_fir_pkg.sv ====
// shared constants and carrier types for the programmable equalizer fir
package eq_fir_pkg;

   // register map, byte addresses on the apb
   localparam logic [11:0] ADDR_CTRL      = 12'h000;
   localparam logic [11:0] ADDR_STAT      = 12'h004;
   localparam logic [11:0] ADDR_COEF_A    = 12'h040;
   localparam logic [11:0] ADDR_COEF_B    = 12'h080;

   // ctrl field positions
   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_SHARE_BIT = 4;
   localparam int CTRL_MERGE_BIT = 5;
   localparam int CTRL_WGT_LSB   = 8;

   // stat field positions
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_TV_BIT     = 1;
   localparam int STAT_PHASE_BIT  = 2;
   localparam int STAT_SAT_BIT    = 3;

   // filter shape
   localparam int NTAPS      = 9;
   localparam int CTR_TAP    = 4;
   localparam int SAMP_W     = 12;
   localparam int CTR_W      = 18;
   localparam int NC_W       = 12;
   localparam int ACC_W      = 36;
   localparam int FRAC_W     = 16;
   localparam int WGT_MAX    = 6;

   localparam logic [1:0]        MODE_OFF      = 2'h0;
   localparam logic [1:0]        MODE_ON       = 2'h2;
   localparam logic [CTR_W-1:0]  CTR_RESET     = 18'h10000;
   localparam logic [2:0]        WGT_RESET     = 3'h0;
   localparam logic [FRAC_W-1:0] HALF_LSB      = 16'h8000;
   localparam logic [SAMP_W-1:0] SAMP_MAX      = 12'h7ff;
   localparam logic [SAMP_W-1:0] SAMP_MIN      = 12'h800;

   typedef enum logic [1:0] {EQ_BYPASS, EQ_DUAL, EQ_SINGLE, EQ_TV} eq_mode_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic              valid;
      logic [SAMP_W-1:0] a;
      logic [SAMP_W-1:0] b;
   } samp_t;

endpackage : eq_fir_pkg

// ==== hdl/programmable_equalizer_fir.sv ====
// nine-tap equalizer fir on the converter sample stream, apb configured
// Contract
// - converter samples feed the filter; channel a equalized when the filter is enabled, channel b in dual mode only.
// - mode 0 off; mode 2 with share/merge 00 dual, 11 single, 01 time-varying.
// - dual mode gives each channel its own nine independent coefficients.
// - center tap is 18 bits with lsb weight two to minus sixteen.
// - non-center taps are 12 bits, lsb weight two to minus 10..16.
// - one weight setting applies to all non-center taps of a filter.
// - time-varying mode alternates the two coefficient sets sample by sample.
// - each time-varying coefficient set holds nine independent coefficients.
// - full precision inside; rounding happens only at the filter output.
// - output rounds to nearest, ties to even, and saturates on overflow.
`timescale 1ns/1ps
`default_nettype none

module programmable_equalizer_fir
(
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire eq_fir_pkg::apb_req_t apb_req,
   output var  eq_fir_pkg::apb_rsp_t apb_rsp,
   input  wire eq_fir_pkg::samp_t    samp_in,
   output var  eq_fir_pkg::samp_t    samp_out
);
   import eq_fir_pkg::*;

   typedef logic [NTAPS-1:0][CTR_W-1:0]  coef_set_t;
   typedef logic [NTAPS-1:0][SAMP_W-1:0] dline_t;

   typedef struct packed {
      logic              sat;
      logic [SAMP_W-1:0] val;
   } rnd_t;

   typedef struct packed {
      logic [1:0] mode_sel;
      logic       share_sel;
      logic       merge_sel;
      logic [2:0] wgt;
      logic       sat_sticky;
      logic       phase;
      coef_set_t  coef_a;
      coef_set_t  coef_b;
      dline_t     dl_a;
      dline_t     dl_b;
      samp_t      out;
      apb_rsp_t   rsp;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // reserved share/merge pairs fall back to bypass, never a guessed mode
   function automatic eq_mode_t decode_mode(input logic [1:0] m,
                                            input logic       sh,
                                            input logic       mg);
      eq_mode_t r;
      r = EQ_BYPASS;
      if (m == MODE_ON)
      begin
         if (!sh && !mg)
            r = EQ_DUAL;
         else if (sh && mg)
            r = EQ_SINGLE;
         else if (!sh && mg)
            r = EQ_TV;
      end
      return r;
   endfunction : decode_mode

   // one window test for both coefficient groups; misaligned words miss it
   function automatic logic in_group(input logic [11:0] addr,
                                     input logic [11:0] base);
      logic [11:0] off;
      off = addr - base;
      return (addr >= base) && (off[11:2] < 10'(NTAPS)) && (addr[1:0] == 2'h0);
   endfunction : in_group

   function automatic logic [3:0] coef_index(input logic [11:0] addr,
                                             input logic [11:0] base);
      logic [11:0] off;
      off = addr - base;
      return off[5:2];
   endfunction : coef_index

   // non-center slots keep only the low 12 bits and read back zero above
   function automatic logic [CTR_W-1:0] coef_word(input logic [3:0]  idx,
                                                  input logic [31:0] d);
      logic [CTR_W-1:0] r;
      if (idx == 4'(CTR_TAP))
         r = d[CTR_W-1:0];
      else
         r = {6'h0, d[NC_W-1:0]};
      return r;
   endfunction : coef_word

   // unity center tap, so the filter comes up transparent
   function automatic coef_set_t unity_set();
      coef_set_t s;
      s          = '0;
      s[CTR_TAP] = CTR_RESET;
      return s;
   endfunction : unity_set

   // all products aligned to the 2^-16 grid so the sum is exact
   function automatic logic signed [ACC_W-1:0] fir_sum(input dline_t    x,
                                                        input coef_set_t c,
                                                        input logic [2:0] w);
      logic signed [ACC_W-1:0] acc;
      logic signed [ACC_W-1:0] xs;
      logic signed [ACC_W-1:0] cs;
      logic signed [ACC_W-1:0] p;
      logic [2:0]              sh;
      acc = '0;
      // shift lifts the coarser non-center grid onto the 2^-16 grid
      sh  = 3'(WGT_MAX) - ((w > 3'(WGT_MAX)) ? 3'(WGT_MAX) : w);
      for (int i = 0; i < NTAPS; i++)
      begin
         xs = ACC_W'(signed'(x[i]));
         if (i == CTR_TAP)
         begin
            cs = ACC_W'(signed'(c[i]));
            p  = xs * cs;
         end
         else
         begin
            cs = ACC_W'(signed'(c[i][NC_W-1:0]));
            p  = (xs * cs) <<< sh;
         end
         acc = acc + p;
      end
      return acc;
   endfunction : fir_sum

   // ties go to the even code so rounding adds no dc bias
   function automatic rnd_t round_sat(input logic signed [ACC_W-1:0] v);
      rnd_t                    r;
      logic signed [ACC_W-1:0] q;
      logic [FRAC_W-1:0]       f;
      q = v >>> FRAC_W;
      f = v[FRAC_W-1:0];
      if (f > HALF_LSB || (f == HALF_LSB && q[0]))
         q = q + ACC_W'(1);
      r.sat = 1'b0;
      if (q > ACC_W'(signed'(SAMP_MAX)))
      begin
         r.val = SAMP_MAX;
         r.sat = 1'b1;
      end
      else if (q < ACC_W'(signed'(SAMP_MIN)))
      begin
         r.val = SAMP_MIN;
         r.sat = 1'b1;
      end
      else
         r.val = q[SAMP_W-1:0];
      return r;
   endfunction : round_sat

   eq_mode_t mode;
   logic     acc_phase;
   logic     wr_en;
   logic     in_a;
   logic     in_b;
   logic [3:0] idx_a;
   logic [3:0] idx_b;
   coef_set_t   set_a;
   dline_t   dla_new;
   dline_t   dlb_new;
   rnd_t     ya;
   rnd_t     yb;
   logic [31:0] rd;
   logic        rd_err;

   always_comb
   begin
      st_nxt = st_r;
      mode   = decode_mode(st_r.mode_sel, st_r.share_sel, st_r.merge_sel);

      // apb: no wait state; pready comes from a flop set in the setup phase
      // the flop keeps address decode off the pready output path
      acc_phase = apb_req.psel && apb_req.penable && st_r.rsp.pready;
      idx_a = coef_index(apb_req.paddr, ADDR_COEF_A);
      idx_b = coef_index(apb_req.paddr, ADDR_COEF_B);
      in_a  = in_group(apb_req.paddr, ADDR_COEF_A);
      in_b  = in_group(apb_req.paddr, ADDR_COEF_B);

      rd     = '0;
      rd_err = 1'b0;
      if (apb_req.paddr == ADDR_CTRL)
      begin
         rd[CTRL_MODE_LSB +: 2]  = st_r.mode_sel;
         rd[CTRL_SHARE_BIT]      = st_r.share_sel;
         rd[CTRL_MERGE_BIT]      = st_r.merge_sel;
         rd[CTRL_WGT_LSB +: 3]   = st_r.wgt;
      end
      else if (apb_req.paddr == ADDR_STAT)
      begin
         rd[STAT_ACTIVE_BIT] = (mode != EQ_BYPASS);
         rd[STAT_TV_BIT]     = (mode == EQ_TV);
         rd[STAT_PHASE_BIT]  = st_r.phase;
         rd[STAT_SAT_BIT]    = st_r.sat_sticky;
      end
      else if (in_a)
         rd[CTR_W-1:0] = st_r.coef_a[idx_a];
      else if (in_b)
         rd[CTR_W-1:0] = st_r.coef_b[idx_b];
      else
         rd_err = 1'b1;

      st_nxt.rsp.pready = apb_req.psel && !apb_req.penable;
      if (apb_req.psel && !apb_req.penable)
      begin
         st_nxt.rsp.prdata  = apb_req.pwrite ? 32'h0 : rd;
         st_nxt.rsp.pslverr = rd_err;
      end
      else if (acc_phase)
      begin
         st_nxt.rsp.pslverr = 1'b0;
      end

      wr_en = acc_phase && apb_req.pwrite && !rd_err;
      if (wr_en && apb_req.paddr == ADDR_CTRL)
      begin
         st_nxt.mode_sel  = apb_req.pwdata[CTRL_MODE_LSB +: 2];
         st_nxt.share_sel = apb_req.pwdata[CTRL_SHARE_BIT];
         st_nxt.merge_sel = apb_req.pwdata[CTRL_MERGE_BIT];
         st_nxt.wgt       = apb_req.pwdata[CTRL_WGT_LSB +: 3];
      end
      if (wr_en && apb_req.paddr == ADDR_STAT && apb_req.pwdata[STAT_SAT_BIT])
         st_nxt.sat_sticky = 1'b0;
      // an out-of-group address never writes, so a stray index cannot land
      if (wr_en && in_a)
         st_nxt.coef_a[idx_a] = coef_word(idx_a, apb_req.pwdata);
      if (wr_en && in_b)
         st_nxt.coef_b[idx_b] = coef_word(idx_b, apb_req.pwdata);

      // sample path; both filters run every cycle and the mode only muxes,
      // trading area for a datapath whose timing never depends on the mode
      dla_new = {st_r.dl_a[NTAPS-2:0], samp_in.a};
      dlb_new = {st_r.dl_b[NTAPS-2:0], samp_in.b};
      // time-varying phase 1 hands this sample to set b
      set_a = (mode == EQ_TV && st_r.phase) ? st_r.coef_b : st_r.coef_a;
      ya = round_sat(fir_sum(dla_new, set_a, st_r.wgt));
      yb = round_sat(fir_sum(dlb_new, st_r.coef_b, st_r.wgt));

      st_nxt.out.valid = samp_in.valid;
      if (samp_in.valid)
      begin
         // history shifts in every mode, so a mode switch starts on real samples
         st_nxt.dl_a = dla_new;
         st_nxt.dl_b = dlb_new;
         unique case (mode)
            EQ_BYPASS:
            begin
               st_nxt.out.a = samp_in.a;
               st_nxt.out.b = samp_in.b;
            end
            EQ_DUAL:
            begin
               st_nxt.out.a = ya.val;
               st_nxt.out.b = yb.val;
            end
            EQ_SINGLE, EQ_TV:
            begin
               st_nxt.out.a = ya.val;
               st_nxt.out.b = samp_in.b;
            end
         endcase
         if (mode == EQ_TV)
            st_nxt.phase = !st_r.phase;
         // only outputs that actually leave the block raise the flag
         // set wins over a same-cycle clear
         if ((mode != EQ_BYPASS && ya.sat) || (mode == EQ_DUAL && yb.sat))
            st_nxt.sat_sticky = 1'b1;
      end
      // any other mode parks the phase, so time-varying always opens on set a
      if (mode != EQ_TV)
         st_nxt.phase = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_r            <= '0;
         st_r.wgt        <= WGT_RESET;
         st_r.mode_sel   <= MODE_OFF;
         st_r.coef_a     <= unity_set();
         st_r.coef_b     <= unity_set();
      end
      else
         st_r <= st_nxt;
   end

   assign apb_rsp  = st_r.rsp;
   assign samp_out = st_r.out;

endmodule : programmable_equalizer_fir

`default_nettype wire

// ==== sim/programmable_equalizer_fir_chk.sv ====
// port-level assertions for the equalizer fir
`timescale 1ns/1ps
`default_nettype none
module eq_fir_chk
(
   input wire logic                 clk,
   input wire logic                 rst,
   input wire eq_fir_pkg::apb_req_t apb_req,
   input wire eq_fir_pkg::apb_rsp_t apb_rsp,
   input wire eq_fir_pkg::samp_t    samp_in,
   input wire eq_fir_pkg::samp_t    samp_out
);
   import eq_fir_pkg::*;
   logic [3:0] ctrl_r;
   logic       setup;
   logic       ctrl_wr;
   logic       byp;
   logic       dual;
   assign setup = apb_req.psel && !apb_req.penable;
   assign ctrl_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready
                    && apb_req.paddr == ADDR_CTRL;
   assign byp = ctrl_r[1:0] != MODE_ON || ctrl_r[3:2] == 2'h1;
   assign dual = ctrl_r == {2'h0, MODE_ON};
   // mode mirror, updated on the same edge as the block's own copy
   always_ff @(posedge clk)
      if (rst)
         ctrl_r <= 4'h0;
      else if (ctrl_wr)
         ctrl_r <= {apb_req.pwdata[5:4], apb_req.pwdata[1:0]};
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   AST_RDY_AFTER_SETUP: assert property (setup |=> apb_rsp.pready)
      else $error("no pready after setup");
   AST_RDY_ONE_CYCLE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready longer than one cycle");
   AST_RDY_CAUSE: assert property (apb_rsp.pready |-> $past(setup))
      else $error("pready without setup");
   AST_ERR_SHAPE: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
      else $error("bad error response");
   AST_OUT_LATENCY: assert property (samp_in.valid |=> samp_out.valid)
      else $error("output valid missing");
   AST_OUT_CAUSE: assert property (samp_out.valid |-> $past(samp_in.valid))
      else $error("output valid without input");
   AST_OUT_HOLD: assert property (!samp_in.valid |=> $stable(samp_out.a) && $stable(samp_out.b))
      else $error("output changed without input");
   AST_BYPASS_A: assert property (samp_in.valid && byp |=> samp_out.a == $past(samp_in.a))
      else $error("bypass altered channel a");
   AST_PASS_B: assert property (samp_in.valid && !dual |=> samp_out.b == $past(samp_in.b))
      else $error("channel b altered outside dual mode");
endmodule : eq_fir_chk
bind programmable_equalizer_fir eq_fir_chk u_chk (.clk(clk), .rst(rst), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .samp_in(samp_in), .samp_out(samp_out));
`default_nettype wire

// ==== sim/programmable_equalizer_fir_tb_top.sv ====
// self-checking bench for the equalizer fir
`timescale 1ns/1ps
`default_nettype none
module programmable_equalizer_fir_tb_top;
   import eq_fir_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        push = 1'b0;
   logic [11:0] pa = 12'h000;
   logic [11:0] pb = 12'h000;
   apb_req_t    req = '0;
   apb_rsp_t    rsp;
   samp_t       si;
   samp_t       so;
   int          err_total = 0;
   int          num_checks = 0;
   int          cyc = 0;
   int          mode = 0;
   int          w = 0;
   int          ph = 0;
   int          ca[9];
   int          cb[9];
   int          ha[9];
   int          hb[9];

   always #4 clk = ~clk;

   programmable_equalizer_fir dut (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
      .samp_in(si), .samp_out(so));
   samp_src src (.clk(clk), .push(push), .pa(pa), .pb(pb), .samp(si));

   task automatic final_report;
      if (err_total == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         err_total++;
         final_report();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
                      output logic [31:0] q, output logic e);
      @(posedge clk);
      req <= '{1'b1, 1'b0, wr, ad, wd};
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (rsp.pready !== 1'b1);
      q = rsp.prdata;
      e = rsp.pslverr;
      req <= '0;
   endtask : apb

   task automatic wr(input logic [11:0] ad, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, ad, d, q, e);
   endtask : wr

   task automatic rchk(input logic [11:0] ad, input logic [31:0] x, input logic xe);
      logic [31:0] q;
      logic        e;
      apb(1'b0, ad, 32'h0, q, e);
      chk(q, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask : rchk

   // full-precision sum at 2^-16, one rounding at the end
   function automatic int fir(input int h[9], input int c[9]);
      longint acc = 0;
      longint q;
      for (int i = 0; i < 9; i++)
         acc += (i == CTR_TAP) ? longint'(c[i]) * h[i]
                : (longint'(c[i]) * h[i]) <<< (WGT_MAX - (w > WGT_MAX ? WGT_MAX : w));
      q = acc >>> 16;
      if (acc[15:0] > 16'h8000 || (acc[15:0] == 16'h8000 && q[0]))
         q++;
      return q > 2047 ? 2047 : q < -2048 ? -2048 : int'(q);
   endfunction : fir

   task automatic send(input int xa, input int xb);
      int ea;
      int eb;
      int n;
      for (int i = 8; i > 0; i--)
      begin
         ha[i] = ha[i-1];
         hb[i] = hb[i-1];
      end
      ha[0] = xa;
      hb[0] = xb;
      ea = xa;
      eb = xb;
      if (mode == 'h02 || mode == 'h32 || (mode == 'h22 && ph == 0))
         ea = fir(ha, ca);
      if (mode == 'h22 && ph == 1)
         ea = fir(ha, cb);
      if (mode == 'h02)
         eb = fir(hb, cb);
      if (mode == 'h22)
         ph = 1 - ph;
      @(posedge clk);
      push <= 1'b1;
      pa <= xa[11:0];
      pb <= xb[11:0];
      @(posedge clk);
      push <= 1'b0;
      n = 0;
      while (so.valid !== 1'b1 && n++ < 4)
         @(posedge clk);
      chk(32'(so.valid), 32'h1);
      chk(32'(so.a), 32'(ea[11:0]));
      chk(32'(so.b), 32'(eb[11:0]));
   endtask : send

   task automatic set_mode(input int m, input int wt);
      mode = m;
      w = wt;
      ph = 0;
      wr(ADDR_CTRL, 32'(m) | (32'(wt) << 8));
   endtask : set_mode

   task automatic load(input logic [11:0] base, input int k, output int c[9]);
      for (int i = 0; i < 9; i++)
      begin
         c[i] = (i == CTR_TAP) ? 'h8000 + k * 'h1000 : (i * k * 37) % 2048 - k * 40;
         wr(base + 12'(4 * i), 32'(c[i]));
      end
   endtask : load

   task automatic t_regs;
      rchk(ADDR_CTRL, 32'h0, 1'b0);
      rchk(ADDR_STAT, 32'h0, 1'b0);
      rchk(ADDR_COEF_A + 12'h010, 32'h10000, 1'b0);
      rchk(ADDR_COEF_B + 12'h010, 32'h10000, 1'b0);
      wr(ADDR_COEF_A, 32'hffffffff);
      wr(ADDR_COEF_A + 12'h010, 32'hffffffff);
      rchk(ADDR_COEF_A, 32'h00000fff, 1'b0);
      rchk(ADDR_COEF_A + 12'h010, 32'h0003ffff, 1'b0);
      rchk(12'h100, 32'h0, 1'b1);
   endtask : t_regs

   task automatic t_bypass;
      int ml[4] = '{'h00, 'h12, 'h01, 'h33};
      foreach (ml[i])
      begin
         set_mode(ml[i], 0);
         send(-2048 + i, 2047 - i);
      end
   endtask : t_bypass

   task automatic t_dual;
      load(ADDR_COEF_A, 1, ca);
      load(ADDR_COEF_B, 2, cb);
      // the last step uses an oversize weight code, which acts as the finest
      for (int k = 0; k <= WGT_MAX + 1; k++)
      begin
         set_mode('h02, k);
         send(300 * k - 900, 250 - 75 * k);
         send(-123, 511);
      end
   endtask : t_dual

   // half-weight center tap makes every odd sample a tie
   task automatic t_single;
      load(ADDR_COEF_A, 0, ca);
      set_mode('h32, 6);
      for (int x = -9; x <= 9; x += 2)
         send(x, -x);
   endtask : t_single

   task automatic t_sat;
      load(ADDR_COEF_A, 23, ca);
      set_mode('h32, 6);
      repeat (3) send(2047, 0);
      rchk(ADDR_STAT, 32'h9, 1'b0);
      wr(ADDR_STAT, 32'h8);
      rchk(ADDR_STAT, 32'h1, 1'b0);
   endtask : t_sat

   task automatic t_tv;
      load(ADDR_COEF_A, 3, ca);
      load(ADDR_COEF_B, 5, cb);
      set_mode('h22, 6);
      for (int n = 0; n < 5; n++)
         send(40 * n - 70, 9 - n);
      rchk(ADDR_STAT, 32'h7, 1'b0);
   endtask : t_tv

   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_bypass();
      t_dual();
      t_single();
      t_sat();
      t_tv();
      final_report();
   end
endmodule : programmable_equalizer_fir_tb_top
`default_nettype wire

// ==== sim/samp_src.sv ====
// converter sample source feeding the equalizer
`timescale 1ns/1ps
`default_nettype none
module samp_src
(
   input  wire logic                          clk,
   input  wire logic                          push,
   input  wire logic [eq_fir_pkg::SAMP_W-1:0] pa,
   input  wire logic [eq_fir_pkg::SAMP_W-1:0] pb,
   output var  eq_fir_pkg::samp_t             samp
);
   import eq_fir_pkg::*;
   // idle words flip so stale data never passes for a sample
   always_ff @(posedge clk)
   begin
      samp.valid <= push;
      samp.a <= push ? pa : ~samp.a;
      samp.b <= push ? pb : ~samp.b;
   end
endmodule : samp_src
`default_nettype wire
